// *** hdl/quad_half_bridge_defs.vh ***
// Register map, field positions and reset values for the half-bridge control.
`ifndef QUAD_HALF_BRIDGE_DEFS_VH
`define QUAD_HALF_BRIDGE_DEFS_VH
`define ADDR_BRIDGE_OUTPUT_DRIVE 8'h04
`define ADDR_BRIDGE_CONTROL 8'h08
`define ADDR_SYSTEM_CONTROL 8'h0c
`define ADDR_SYSTEM_STATUS 8'h30
`define ADDR_INTERRUPT_FLAG 8'h40
`define ADDR_SENSE_STATUS 8'h44
`define IDX_BRIDGE_OUTPUT_DRIVE 8'h01
`define IDX_BRIDGE_CONTROL 8'h02
`define IDX_SYSTEM_CONTROL 8'h03
`define RESET_BYTE 8'h00
`define CTL_OFFSET_CHOP 4
`define CTL_LIMIT_MSB 3
`define CTL_LIMIT_LSB 1
`define CTL_SENSE_GAIN 0
`define SYS_POWER_ENABLE 7
`define SYS_LAMP_SWITCH 0
`define SYS_TEMP_RESET_ENABLE 1
`define STAT_BRIDGE_OC 1
`define STAT_HV 2
`define STAT_LV 3
`define IFR_TEMP 0
`define IFR_HV 1
`define IFR_LV 2
`define LIMIT_FIRST_ACTIVE 3'h3
`define BBM_CYCLES 2'h2
`endif

// *** hdl/quad_half_bridge_control.v ***
// Quad half-bridge and lamp switch control logic with AHB-Lite registers.
//
// The AHB-Lite slave port was decided locally.
`include "quad_half_bridge_defs.vh"
`default_nettype none
module quad_half_bridge_control #(
	parameter BRIDGES = 4
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire chop_frequency_input,
	input wire [BRIDGES-1:0] lowside_over_limit,
	input wire [BRIDGES-1:0] lowside_overcurrent,
	input wire [BRIDGES-1:0] highside_overcurrent,
	input wire [BRIDGES-1:0] lowside_gate_off,
	input wire [BRIDGES-1:0] highside_gate_off,
	input wire [BRIDGES-1:0] recirculation_detect,
	input wire low_voltage_detect,
	input wire high_voltage_detect,
	input wire temperature_detect,
	output reg [BRIDGES-1:0] lowside_gate,
	output reg [BRIDGES-1:0] highside_gate,
	output reg lamp_output,
	output reg [2:0] current_limit_select,
	output reg sense_gain_select,
	output reg recirculation_indicator,
	output reg temperature_reset_request
);
	reg [7:0] bridge_output_drive;
	reg [7:0] bridge_control;
	reg [7:0] system_control;
	reg bridge_overcurrent_flag;
	reg low_voltage_flag;
	reg high_voltage_flag;
	reg temperature_warning_flag;
	reg [BRIDGES-1:0] chop_off;
	reg [1:0] chop_sync;
	reg chop_prev;
	reg [BRIDGES-1:0] lim_s1, lim_s2, loc_s1, loc_s2, hoc_s1, hoc_s2;
	reg [BRIDGES-1:0] lgo_s1, lgo_s2, hgo_s1, hgo_s2, rec_s1, rec_s2;
	reg [2:0] volt_s1, volt_s2;
	reg ph_write;
	reg ph_read;
	reg [7:0] ph_addr;

	// Drop of the two-flop sampled level in each bridge's gate paths.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chop_sync <= 2'h0;
			chop_prev <= 1'b0;
			lim_s1 <= {BRIDGES{1'b0}};
			lim_s2 <= {BRIDGES{1'b0}};
			loc_s1 <= {BRIDGES{1'b0}};
			loc_s2 <= {BRIDGES{1'b0}};
			hoc_s1 <= {BRIDGES{1'b0}};
			hoc_s2 <= {BRIDGES{1'b0}};
			lgo_s1 <= {BRIDGES{1'b1}};
			lgo_s2 <= {BRIDGES{1'b1}};
			hgo_s1 <= {BRIDGES{1'b1}};
			hgo_s2 <= {BRIDGES{1'b1}};
			rec_s1 <= {BRIDGES{1'b0}};
			rec_s2 <= {BRIDGES{1'b0}};
			volt_s1 <= 3'h0;
			volt_s2 <= 3'h0;
		end else begin
			chop_sync <= {chop_sync[0], chop_frequency_input};
			chop_prev <= chop_sync[1];
			lim_s1 <= lowside_over_limit;
			lim_s2 <= lim_s1;
			loc_s1 <= lowside_overcurrent;
			loc_s2 <= loc_s1;
			hoc_s1 <= highside_overcurrent;
			hoc_s2 <= hoc_s1;
			lgo_s1 <= lowside_gate_off;
			lgo_s2 <= lgo_s1;
			hgo_s1 <= highside_gate_off;
			hgo_s2 <= hgo_s1;
			rec_s1 <= recirculation_detect;
			rec_s2 <= rec_s1;
			volt_s1 <= {temperature_detect, high_voltage_detect,
				low_voltage_detect};
			volt_s2 <= volt_s1;
		end
	end

	wire chop_rise = chop_sync[1] & ~chop_prev;
	wire chop_fall = ~chop_sync[1] & chop_prev;
	wire limit_active = current_limit_select >= `LIMIT_FIRST_ACTIVE;
	wire voltage_block = low_voltage_flag | high_voltage_flag;
	wire power_on = system_control[`SYS_POWER_ENABLE];
	// A temperature reset request holds every power output off.
	wire temp_trip = volt_s2[2] &
		system_control[`SYS_TEMP_RESET_ENABLE];

	// Bus address phase capture; the slave never inserts wait states.
	wire take = hsel & hready & htrans[1];
	wire wr_sys = ph_write && ph_addr == `ADDR_SYSTEM_CONTROL;
	wire wr_stat = ph_write && ph_addr == `ADDR_SYSTEM_STATUS;
	wire wr_ifr = ph_write && ph_addr == `ADDR_INTERRUPT_FLAG;
	wire clr_oc = (wr_stat & hwdata[`STAT_BRIDGE_OC]);
	wire clr_lv = (wr_stat & hwdata[`STAT_LV]) |
		(wr_ifr & hwdata[`IFR_LV]);
	wire clr_hv = (wr_stat & hwdata[`STAT_HV]) |
		(wr_ifr & hwdata[`IFR_HV]);

	function [7:0] read_mux;
		input [7:0] a;
		begin
			case (a)
			`ADDR_BRIDGE_OUTPUT_DRIVE: read_mux = bridge_output_drive;
			`ADDR_BRIDGE_CONTROL: read_mux = bridge_control;
			`ADDR_SYSTEM_CONTROL: read_mux = system_control;
			`ADDR_SYSTEM_STATUS: read_mux = {4'h0, low_voltage_flag,
				high_voltage_flag, bridge_overcurrent_flag,
				temperature_warning_flag};
			`ADDR_INTERRUPT_FLAG: read_mux = {5'h0, low_voltage_flag,
				high_voltage_flag, temperature_warning_flag};
			`ADDR_SENSE_STATUS: read_mux = {lowside_gate, highside_gate};
			default: read_mux = 8'h00;
			endcase
		end
	endfunction

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_write <= 1'b0;
			ph_read <= 1'b0;
			ph_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ph_write <= take & hwrite;
			ph_read <= take & ~hwrite;
			ph_addr <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take & ~hwrite)
				hrdata <= {24'h000000, read_mux(haddr[7:0])};
		end
	end

	// Register writes and sticky protection flags; a set beats a clear.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bridge_output_drive <= `RESET_BYTE;
			bridge_control <= `RESET_BYTE;
			system_control <= `RESET_BYTE;
			bridge_overcurrent_flag <= 1'b0;
			low_voltage_flag <= 1'b0;
			high_voltage_flag <= 1'b0;
			temperature_warning_flag <= 1'b0;
		end else begin
			if (ph_write && ph_addr == `ADDR_BRIDGE_OUTPUT_DRIVE)
				bridge_output_drive <= hwdata[7:0];
			if (ph_write && ph_addr == `ADDR_BRIDGE_CONTROL)
				bridge_control <= {3'h0, hwdata[4:0]};
			if (wr_sys)
				system_control <= {hwdata[7], 5'h00, hwdata[1:0]};
			if (|loc_s2 | |hoc_s2)
				bridge_overcurrent_flag <= 1'b1;
			else if (clr_oc)
				bridge_overcurrent_flag <= 1'b0;
			if (volt_s2[0])
				low_voltage_flag <= 1'b1;
			else if (clr_lv)
				low_voltage_flag <= 1'b0;
			if (volt_s2[1])
				high_voltage_flag <= 1'b1;
			else if (clr_hv)
				high_voltage_flag <= 1'b0;
			if (volt_s2[2])
				temperature_warning_flag <= 1'b1;
			else if (wr_ifr & hwdata[`IFR_TEMP])
				temperature_warning_flag <= 1'b0;
		end
	end

	// Each overcurrent shutdown group is remembered until a flag clear write sees its own fault gone.
	reg hs_tripped;
	reg ls_tripped;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hs_tripped <= 1'b0;
			ls_tripped <= 1'b0;
		end else begin
			if (|hoc_s2)
				hs_tripped <= 1'b1;
			else if (clr_oc)
				hs_tripped <= 1'b0;
			if (|loc_s2)
				ls_tripped <= 1'b1;
			else if (clr_oc)
				ls_tripped <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < BRIDGES; g = g + 1) begin : bridge
			wire want_h = bridge_output_drive[2*g+1];
			// High side has priority over low side.
			wire want_l = bridge_output_drive[2*g] & ~want_h;
			wire rearm = bridge_control[`CTL_OFFSET_CHOP] && g >= 2 ?
				chop_fall : chop_rise;
			wire allow = power_on & ~voltage_block &
				~temp_trip;
			wire next_h = allow & want_h & ~hs_tripped;
			wire next_l = allow & want_l & ~ls_tripped &
				~chop_off[g];
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					chop_off[g] <= 1'b0;
					highside_gate[g] <= 1'b0;
					lowside_gate[g] <= 1'b0;
				end else begin
					if (limit_active & lim_s2[g] & lowside_gate[g])
						chop_off[g] <= 1'b1;
					else if (rearm | ~limit_active)
						chop_off[g] <= 1'b0;
					// Turn-on waits for the other gate to read off.
					highside_gate[g] <= next_h & ~lowside_gate[g] &
						lgo_s2[g];
					lowside_gate[g] <= next_l & ~highside_gate[g] &
						hgo_s2[g];
				end
			end
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lamp_output <= 1'b0;
			current_limit_select <= 3'h0;
			sense_gain_select <= 1'b0;
			recirculation_indicator <= 1'b0;
			temperature_reset_request <= 1'b0;
		end else begin
			lamp_output <= power_on & system_control[`SYS_LAMP_SWITCH] &
				~voltage_block & ~temp_trip;
			current_limit_select <=
				bridge_control[`CTL_LIMIT_MSB:`CTL_LIMIT_LSB];
			sense_gain_select <= bridge_control[`CTL_SENSE_GAIN];
			recirculation_indicator <= |rec_s2;
			temperature_reset_request <= temp_trip;
		end
	end
endmodule
`default_nettype wire

// *** tb/quad_half_bridge_asserts.sv ***
// Port assertions for the quad half-bridge control.
`default_nettype none
module quad_half_bridge_asserts #(
	parameter BRIDGES = 4
) (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire [BRIDGES-1:0] lowside_overcurrent,
	input wire [BRIDGES-1:0] highside_overcurrent,
	input wire [BRIDGES-1:0] recirculation_detect,
	input wire low_voltage_detect,
	input wire high_voltage_detect,
	input wire [BRIDGES-1:0] lowside_gate,
	input wire [BRIDGES-1:0] highside_gate,
	input wire lamp_output,
	input wire recirculation_indicator
);
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_never_both: assert property (!(lowside_gate & highside_gate))
		else $error("Both gates of a bridge on");
	a_ready_high: assert property (hreadyout)
		else $error("Wait state inserted");
	a_resp_okay: assert property (!hresp)
		else $error("Error response");
	a_recirculation_indicator_on: assert property ((|recirculation_detect)[*5]
		|-> recirculation_indicator) else $error("Indicator low");
	a_recirculation_indicator_off: assert property ((recirculation_detect == 0)[*5]
		|-> !recirculation_indicator) else $error("Indicator high");
	a_high_trip: assert property ((|highside_overcurrent)[*5]
		|-> highside_gate == 0) else $error("High side not off");
	a_low_trip: assert property ((|lowside_overcurrent)[*5]
		|-> lowside_gate == 0) else $error("Low side not off");
	a_volt_off: assert property ((low_voltage_detect |
		high_voltage_detect)[*5] |-> !(lowside_gate | highside_gate)
		&& !lamp_output) else $error("Outputs on in voltage fault");
endmodule
bind quad_half_bridge_control quad_half_bridge_asserts #(.BRIDGES(BRIDGES))
	u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
	.hresp(hresp), .lowside_overcurrent(lowside_overcurrent),
	.highside_overcurrent(highside_overcurrent),
	.recirculation_detect(recirculation_detect),
	.low_voltage_detect(low_voltage_detect),
	.high_voltage_detect(high_voltage_detect),
	.lowside_gate(lowside_gate), .highside_gate(highside_gate),
	.lamp_output(lamp_output),
	.recirculation_indicator(recirculation_indicator));
`default_nettype wire

// *** tb/chop_source.sv ***
// Free-running chop frequency source feeding the current limiter.
`default_nettype none
module chop_source #(
	parameter int HALF = 1000
) (
	input wire logic hclk,
	output logic chop
);
	timeunit 1ns;
	timeprecision 100ps;
	int n = 0;
	initial chop = 1'b0;
	// A half period of 1000 cycles gives 20 kHz at 40 MHz.
	always @(posedge hclk) begin
		n <= (n == HALF - 1) ? 0 : n + 1;
		if (n == HALF - 1)
			chop <= ~chop;
	end
endmodule
`default_nettype wire

// *** tb/tb_quad_half_bridge_control.sv ***
// Self-checking bench for the quad half-bridge control block.
`default_nettype none
module tb_quad_half_bridge_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, chop;
	logic lamp, rci, lv, hv, sgs, tmp, trq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] cls;
	logic [3:0] lol, loc, hoc, lo_off, hi_off, rcd, lo, hi;
	logic [7:0] d;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	quad_half_bridge_control dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chop_frequency_input(chop),
		.lowside_over_limit(lol), .lowside_overcurrent(loc),
		.highside_overcurrent(hoc), .lowside_gate_off(lo_off),
		.highside_gate_off(hi_off), .recirculation_detect(rcd),
		.low_voltage_detect(lv), .high_voltage_detect(hv),
		.temperature_detect(tmp), .lowside_gate(lo), .highside_gate(hi),
		.lamp_output(lamp), .current_limit_select(cls),
		.sense_gain_select(sgs), .recirculation_indicator(rci),
		.temperature_reset_request(trq));
	chop_source #(.HALF(1000)) u_chop (.hclk(hclk), .chop(chop));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task summarize;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// The gate-off sense lines follow the gates one cycle late.
	always @(posedge hclk) begin
		lo_off <= ~lo;
		hi_off <= ~hi;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			summarize;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task wait_lvl(input logic v);
		do @(posedge hclk); while (chop !== v);
	endtask
	// Expected {low gates, high gates}; the high side wins a conflict.
	function logic [7:0] gates(input logic [7:0] v);
		logic [3:0] l, h;
		for (int i = 0; i < 4; i++) begin
			h[i] = v[2*i+1];
			l[i] = v[2*i] & ~v[2*i+1];
		end
		return {l, h};
	endfunction
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		{lol, loc, hoc, rcd, lv, hv, tmp} = '0;
		lo_off = 4'hf;
		hi_off = 4'hf;
		rd = $urandom(78692);
		tick(8);
		hresetn <= 1'b1;
		tick(1);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h20, 32'h0);
		chk({lo, hi}, 32'h0);
		bus(1'b1, 8'h0c, 32'h80);
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hff : 8'($urandom);
			rcd <= 4'($urandom);
			bus(1'b1, 8'h04, {24'h0, d});
			tick(10);
			chk({lo, hi}, gates(d));
			chk(rci, |rcd);
			rchk(8'h04, d);
		end
		bus(1'b1, 8'h0c, 32'h01);
		tick(10);
		chk({lo, hi, lamp}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = {3'h0, 1'($urandom), 3'(i), 1'($urandom)};
			bus(1'b1, 8'h08, {24'h0, d});
			rchk(8'h08, d);
			chk({cls, sgs}, d[3:0]);
		end
		bus(1'b1, 8'h0c, 32'h81);
		for (int k = 0; k < 2; k++) begin
			d = k ? 8'h55 : 8'haa;
			bus(1'b1, 8'h04, {24'h0, d});
			tick(10);
			chk(lamp, 1'b1);
			if (k)
				loc <= 4'h4;
			else
				hoc <= 4'h2;
			tick(8);
			{loc, hoc} <= '0;
			tick(6);
			chk({lo, hi}, 32'h0);
			bus(1'b1, 8'h30, 32'h0);
			rchk(8'h30, 32'h2);
			rchk(8'h04, d);
			bus(1'b1, 8'h30, 32'h2);
			tick(10);
			chk({lo, hi}, gates(d));
		end
		lv <= 1'b1;
		tick(8);
		lv <= 1'b0;
		tick(6);
		chk({lo, hi, lamp}, 32'h0);
		rchk(8'h40, 32'h4);
		bus(1'b1, 8'h40, 32'h4);
		tick(10);
		chk({lo, hi, lamp}, {gates(d), 1'b1});
		hv <= 1'b1;
		tick(8);
		bus(1'b1, 8'h40, 32'h2);
		tick(10);
		rchk(8'h40, 32'h2);
		chk({lo, hi, lamp}, 32'h0);
		hv <= 1'b0;
		tick(6);
		bus(1'b1, 8'h40, 32'h2);
		bus(1'b1, 8'h0c, 32'h83);
		tmp <= 1'b1;
		tick(8);
		chk({trq, lo, hi, lamp}, 10'h200);
		tmp <= 1'b0;
		tick(6);
		rchk(8'h40, 32'h1);
		chk({trq, lo, hi, lamp}, {1'b0, gates(d), 1'b1});
		// Trip just after a restoring edge, release after the other edge.
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 8'h08, k ? 32'h16 : 32'h06);
			bus(1'b1, 8'h04, k ? 32'h10 : 32'h01);
			wait_lvl(k);
			wait_lvl(!k);
			lol <= k ? 4'h4 : 4'h1;
			tick(8);
			chk(lo, 32'h0);
			wait_lvl(k);
			lol <= 4'h0;
			tick(6);
			chk(lo, 32'h0);
			wait_lvl(!k);
			tick(6);
			chk(lo, k ? 4'h4 : 4'h1);
		end
		summarize;
	end
endmodule
`default_nettype wire
